// ===== rtl/wrs_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module wrs_supervisor #(
  parameter logic [15:0] WDO_LONG  = 16'(wrs_pkg::WDO_LONG_TICKS),
  parameter logic [15:0] WDO_MID   = 16'(wrs_pkg::WDO_MID_TICKS),
  parameter logic [15:0] WDO_SHORT = 16'(wrs_pkg::WDO_SHORT_TICKS),
  parameter logic [15:0] WD_RST    = 16'(wrs_pkg::WD_RST_TICKS),
  parameter logic [15:0] POR_DLY   = 16'(wrs_pkg::POR_TICKS),
  parameter logic [16:0] WC_DLY    = 17'(wrs_pkg::WC_CYCLES)
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             xtal_tick,
  input  wire logic             supply_low,
  input  wire wrs_pkg::wrs_sel_t sel,
  input  wire logic             bus_access,
  input  wire logic             wr_stop,
  output logic                  reset_n_out,
  output logic                  reset_n_oe,
  output logic                  nv_busy
);

  // ----------------------------------------
  // period decode
  // ----------------------------------------
  function automatic logic [15:0] period_ticks(input logic [1:0] code);
    logic [15:0] r;
    r = WDO_LONG;
    unique case (code)
      wrs_pkg::SEL_LONG:  r = WDO_LONG;
      wrs_pkg::SEL_MID:   r = WDO_MID;
      wrs_pkg::SEL_SHORT: r = WDO_SHORT;
      wrs_pkg::SEL_OFF:   r = wrs_pkg::CNT_ZERO;
    endcase
    return r;
  endfunction : period_ticks

  wrs_pkg::wrs_state_t q;
  wrs_pkg::wrs_state_t d;
  logic [1:0]          code;
  logic                wd_off;
  logic                wd_expire;

  assign code      = {sel.wdog_period_sel_hi, sel.wdog_period_sel_lo};
  assign wd_off    = (code == wrs_pkg::SEL_OFF);
  assign wd_expire = !wd_off && !bus_access && xtal_tick
                     && (q.wcnt >= period_ticks(code) - wrs_pkg::CNT_ONE);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    unique case (q.mode)
      wrs_pkg::ST_POR: begin
        if (xtal_tick) begin
          d.tcnt = q.tcnt + wrs_pkg::CNT_ONE;
          if (q.tcnt == POR_DLY - wrs_pkg::CNT_ONE) begin
            d.mode = wrs_pkg::ST_RUN;
            d.tcnt = wrs_pkg::CNT_ZERO;
            d.wcnt = wrs_pkg::CNT_ZERO;
          end
        end
      end
      wrs_pkg::ST_RUN: begin
        if (wd_off || bus_access) begin
          d.wcnt = wrs_pkg::CNT_ZERO;
        end else if (wd_expire) begin
          d.mode = wrs_pkg::ST_WDRST;
          d.wcnt = wrs_pkg::CNT_ZERO;
          d.tcnt = wrs_pkg::CNT_ZERO;
        end else if (xtal_tick) begin
          d.wcnt = q.wcnt + wrs_pkg::CNT_ONE;
        end
      end
      wrs_pkg::ST_WDRST: begin
        d.wcnt = wrs_pkg::CNT_ZERO;
        if (xtal_tick) begin
          d.tcnt = q.tcnt + wrs_pkg::CNT_ONE;
          if (q.tcnt == WD_RST - wrs_pkg::CNT_ONE) begin
            d.mode = wrs_pkg::ST_RUN;
            d.tcnt = wrs_pkg::CNT_ZERO;
          end
        end
      end
      wrs_pkg::ST_LOWV: begin
        d.tcnt = wrs_pkg::CNT_ZERO;
        d.wcnt = wrs_pkg::CNT_ZERO;
        if (!supply_low) begin
          d.mode = wrs_pkg::ST_POR; // supply back: rerun power-up delay
        end
      end
    endcase
    // low supply overrides mode and counters; the nonvolatile write runs on
    if (supply_low) begin
      d.mode = wrs_pkg::ST_LOWV;
      d.tcnt = wrs_pkg::CNT_ZERO;
      d.wcnt = wrs_pkg::CNT_ZERO;
    end
    // self-timed nonvolatile write; stops while busy are ignored
    if (q.nv_busy) begin
      d.ncnt = q.ncnt + wrs_pkg::NV_ONE;
      if (q.ncnt == WC_DLY - wrs_pkg::NV_ONE) begin
        d.nv_busy = 1'b0;
        d.ncnt    = wrs_pkg::NV_ZERO;
      end
    end else if (wr_stop) begin
      d.nv_busy = 1'b1;
      d.ncnt    = wrs_pkg::NV_ZERO;
    end
    // open drain: drive low only while asserted
    d.rst_oe  = (d.mode != wrs_pkg::ST_RUN);
    d.rst_lvl = !d.rst_oe;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q.mode    <= wrs_pkg::ST_POR;
      q.tcnt    <= wrs_pkg::CNT_ZERO;
      q.wcnt    <= wrs_pkg::CNT_ZERO;
      q.ncnt    <= wrs_pkg::NV_ZERO;
      q.nv_busy <= 1'b0;
      q.rst_lvl <= 1'b0;
      q.rst_oe  <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign reset_n_out = q.rst_lvl;
  assign reset_n_oe  = q.rst_oe;
  assign nv_busy     = q.nv_busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_expire;
    clk_en && !supply_low && q.mode == wrs_pkg::ST_RUN && wd_expire;
  endsequence

  sequence s_in_wdrst;
    q.mode == wrs_pkg::ST_WDRST && reset_n_oe && !reset_n_out;
  endsequence

  property p_period_bound;
    (q.mode == wrs_pkg::ST_RUN && !wd_off) |-> q.wcnt < period_ticks(code);
  endproperty
  a_period_bound: assert property (p_period_bound)
    else $error("watchdog count beyond selected period");

  property p_off_no_reset;
    (clk_en && !supply_low && q.mode == wrs_pkg::ST_RUN && wd_off)
      |=> q.mode == wrs_pkg::ST_RUN && !reset_n_oe && q.wcnt == wrs_pkg::CNT_ZERO;
  endproperty
  a_off_no_reset: assert property (p_off_no_reset)
    else $error("disabled watchdog caused reset or counted");

  property p_expire;
    s_expire |=> s_in_wdrst;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry did not assert reset");

  property p_wdrst_len;
    (clk_en && !supply_low && q.mode == wrs_pkg::ST_WDRST && xtal_tick
      && q.tcnt == WD_RST - wrs_pkg::CNT_ONE) |=> q.mode == wrs_pkg::ST_RUN && reset_n_out;
  endproperty
  a_wdrst_len: assert property (p_wdrst_len)
    else $error("watchdog reset hold not ended at count");

  property p_wdrst_hold;
    (q.mode == wrs_pkg::ST_WDRST) |-> q.tcnt < WD_RST && reset_n_oe;
  endproperty
  a_wdrst_hold: assert property (p_wdrst_hold)
    else $error("watchdog reset released early");

  property p_por;
    (clk_en && !supply_low && q.mode == wrs_pkg::ST_POR
      && !(xtal_tick && q.tcnt == POR_DLY - wrs_pkg::CNT_ONE)) |=> reset_n_oe [*1];
  endproperty
  a_por: assert property (p_por)
    else $error("power-up reset released early");

  property p_lowv;
    (clk_en && supply_low) |=> (reset_n_oe && !reset_n_out
      && q.mode == wrs_pkg::ST_LOWV);
  endproperty
  a_lowv: assert property (p_lowv)
    else $error("low supply did not pull reset low");

  property p_nv_start;
    (clk_en && wr_stop && !nv_busy) |=> nv_busy && q.ncnt == wrs_pkg::NV_ZERO;
  endproperty
  a_nv_start: assert property (p_nv_start)
    else $error("write stop did not start nonvolatile write");

  property p_od;
    reset_n_oe == !reset_n_out && reset_n_oe == (q.mode != wrs_pkg::ST_RUN);
  endproperty
  a_od: assert property (p_od)
    else $error("reset pin drive inconsistent");

  property p_kick;
    (clk_en && !supply_low && q.mode == wrs_pkg::ST_RUN && bus_access)
      |=> q.wcnt == wrs_pkg::CNT_ZERO && q.mode == wrs_pkg::ST_RUN;
  endproperty
  a_kick: assert property (p_kick)
    else $error("bus access did not restart watchdog");

  property p_freeze;
    !clk_en |=> $stable(q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

endmodule : wrs_supervisor
`default_nettype wire

// ===== rtl/wrs_pkg.sv
package wrs_pkg;

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  localparam int CLK_HZ       = 20000000;
  localparam int XTAL_HZ      = 32768;
  localparam int MS_PER_S     = 1000;

  // ----------------------------------------
  // times in ms, except T_RPD_NS in ns
  // ----------------------------------------
  localparam int T_WDO_LONG_MS  = 1750;
  localparam int T_WDO_MID_MS   = 750;
  localparam int T_WDO_SHORT_MS = 250;
  localparam int T_WD_RST_MS    = 250;
  localparam int T_POR_MS       = 250;
  localparam int T_WC_MS        = 5;
  localparam int T_RPD_NS       = 500;

  // ----------------------------------------
  // derived counts
  // ----------------------------------------
  localparam int WDO_LONG_TICKS  = XTAL_HZ * T_WDO_LONG_MS / MS_PER_S;
  localparam int WDO_MID_TICKS   = XTAL_HZ * T_WDO_MID_MS / MS_PER_S;
  localparam int WDO_SHORT_TICKS = XTAL_HZ * T_WDO_SHORT_MS / MS_PER_S;
  localparam int WD_RST_TICKS    = XTAL_HZ * T_WD_RST_MS / MS_PER_S;
  localparam int POR_TICKS       = XTAL_HZ * T_POR_MS / MS_PER_S;
  localparam int WC_CYCLES       = CLK_HZ / MS_PER_S * T_WC_MS;
  localparam int RPD_CYCLES      = T_RPD_NS / (1000000000 / CLK_HZ);

  // ----------------------------------------
  // widths and period codes
  // ----------------------------------------
  localparam int TW = 16;
  localparam int NW = 17;
  localparam logic [1:0] SEL_LONG  = 2'h0;
  localparam logic [1:0] SEL_MID   = 2'h1;
  localparam logic [1:0] SEL_SHORT = 2'h2;
  localparam logic [1:0] SEL_OFF   = 2'h3;
  localparam logic [TW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [NW-1:0] NV_ZERO  = 17'h00000;
  localparam logic [TW-1:0] CNT_ONE  = 16'h0001;
  localparam logic [NW-1:0] NV_ONE   = 17'h00001;

  typedef enum logic [1:0] {
    ST_POR,
    ST_RUN,
    ST_WDRST,
    ST_LOWV
  } wrs_mode_t;

  typedef struct packed {
    wrs_mode_t         mode;
    logic [TW-1:0]     tcnt;
    logic [TW-1:0]     wcnt;
    logic [NW-1:0]     ncnt;
    logic              nv_busy;
    logic              rst_lvl;
    logic              rst_oe;
  } wrs_state_t;

  typedef struct packed {
    logic wdog_period_sel_hi;
    logic wdog_period_sel_lo;
  } wrs_sel_t;

endpackage : wrs_pkg

// ===== dv/wrs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// host side: pulled-up reset wire, bus kicks
// ----------------------------------------
module wrs_host_model #(
  parameter int PUW_CYC  = 8,
  parameter int KICK_CYC = 8
) (
  input  wire logic clk_sys,
  input  wire logic reset_n_out,
  input  wire logic reset_n_oe,
  input  wire logic kick_en,
  output var  logic bus_access,
  output wire logic reset_wire
);
  int wait_q = 0;
  int gap_q  = 0;
  assign reset_wire = reset_n_oe ? reset_n_out : 1'b1;
  always @(negedge clk_sys) begin
    bus_access <= 1'b0;
    if (reset_wire !== 1'b1) begin
      wait_q <= 0;
    end else if (wait_q < PUW_CYC) begin
      wait_q <= wait_q + 1;
    end else if (kick_en) begin
      gap_q <= (gap_q == KICK_CYC - 1) ? 0 : gap_q + 1;
      bus_access <= (gap_q == 0);
    end
  end
endmodule : wrs_host_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ----------------------------------------
  // shortened counts
  // ----------------------------------------
  localparam logic [15:0] P_LONG = 16'h0008, P_MID = 16'h0006, P_SHORT = 16'h0004;
  localparam logic [15:0] P_RST = 16'h0005, P_POR = 16'h0007;
  localparam logic [16:0] P_WC = 17'h00014;
  logic              clk_sys, rst, clk_en, xtal_tick, supply_low, bus_access, wr_stop, kick_en;
  logic              reset_n_out, reset_n_oe, nv_busy, reset_wire;
  wrs_pkg::wrs_sel_t sel;
  int                fail_count = 0, comparisons = 0, ticks = 0, div = 0;

  wrs_supervisor #(.WDO_LONG(P_LONG), .WDO_MID(P_MID), .WDO_SHORT(P_SHORT), .WD_RST(P_RST),
    .POR_DLY(P_POR), .WC_DLY(P_WC)) uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .xtal_tick(xtal_tick), .supply_low(supply_low), .sel(sel), .bus_access(bus_access),
    .wr_stop(wr_stop), .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe), .nv_busy(nv_busy));
  wrs_host_model #(.PUW_CYC(8), .KICK_CYC(8)) host (.clk_sys(clk_sys),
    .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe), .kick_en(kick_en),
    .bus_access(bus_access), .reset_wire(reset_wire));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // crystal tick every fourth cycle
  always @(negedge clk_sys) begin
    div <= (div == 3) ? 0 : div + 1;
    xtal_tick <= (div == 0);
  end
  always @(posedge clk_sys) if (xtal_tick === 1'b1) ticks <= ticks + 1;

  task automatic chk(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  // ticks until reset_n_oe reaches lvl
  task automatic wait_oe(input logic lvl, input int max_cyc, output int n);
    int t0;
    int k;
    t0 = ticks;
    k = 0;
    while (reset_n_oe !== lvl && k < max_cyc) begin
      @(negedge clk_sys);
      k++;
    end
    n = ticks - t0;
  endtask : wait_oe

  task automatic t_por();
    int n;
    chk_bit(reset_wire, 1'b0);
    chk_bit(reset_n_out, 1'b0);
    wait_oe(1'b0, 1000, n);
    chk(n, int'(P_POR), int'(P_POR) + 1);
    chk_bit(reset_wire, 1'b1);
    $display("test por done");
  endtask : t_por
  task automatic t_periods();
    logic [15:0] per [3];
    int          n;
    per = '{P_LONG, P_MID, P_SHORT};
    for (int i = 0; i < 3; i++) begin
      sel = wrs_pkg::wrs_sel_t'(i[1:0]);
      wait_oe(1'b1, 2000, n);
      chk(n, int'(per[i]), int'(per[i]) + 1);
      chk_bit(reset_wire, 1'b0);
      wait_oe(1'b0, 2000, n);
      chk(n, int'(P_RST), int'(P_RST) + 1);
    end
    $display("test periods done");
  endtask : t_periods
  task automatic t_off();
    int n;
    sel = wrs_pkg::SEL_OFF;
    wait_oe(1'b1, 200, n);
    chk_bit(reset_n_oe, 1'b0);
    sel = wrs_pkg::SEL_SHORT;
    wait_oe(1'b1, 200, n);
    chk(n, int'(P_SHORT), int'(P_SHORT) + 1);
    wait_oe(1'b0, 200, n);
    $display("test off done");
  endtask : t_off
  task automatic t_kick();
    int n;
    kick_en = 1'b1;
    wait_oe(1'b1, 300, n);
    chk_bit(reset_n_oe, 1'b0);
    kick_en = 1'b0;
    wait_oe(1'b1, 300, n);
    chk(n, int'(P_SHORT) - 2, int'(P_SHORT) + 1);
    wait_oe(1'b0, 300, n);
    $display("test kick done");
  endtask : t_kick
  task automatic t_lowv();
    int n;
    supply_low = 1'b1;
    wait_oe(1'b1, wrs_pkg::RPD_CYCLES, n);
    chk_bit(reset_n_oe, 1'b1);
    repeat (10) @(negedge clk_sys);
    chk_bit(reset_wire, 1'b0);
    sel = wrs_pkg::SEL_OFF;
    supply_low = 1'b0;
    wait_oe(1'b0, 1000, n);
    chk(n, int'(P_POR), int'(P_POR) + 1);
    $display("test lowv done");
  endtask : t_lowv
  task automatic t_nv();
    int n;
    for (int r = 0; r < 2; r++) begin
      wr_stop = 1'b1;
      @(negedge clk_sys);
      wr_stop = 1'b0;
      chk_bit(nv_busy, 1'b1);
      n = 0;
      while (nv_busy === 1'b1 && n < 100) begin
        @(negedge clk_sys);
        n++;
        if (n == 5) begin
          wr_stop = 1'b1; // stop while busy is ignored
        end
        if (n == 6) begin
          wr_stop = 1'b0;
        end
        if (r == 1 && n == 8) begin
          clk_en = 1'b0; // ten frozen cycles lengthen the write
        end
        if (r == 1 && n == 18) begin
          clk_en = 1'b1;
        end
      end
      chk(n, int'(P_WC) - 1 + 10 * r, int'(P_WC) + 1 + 10 * r);
    end
    $display("test nv done");
  endtask : t_nv

  task automatic give_verdict();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #2000000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {rst, clk_en, supply_low, wr_stop, kick_en} = 5'h18;
    sel = wrs_pkg::SEL_LONG;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    t_por();
    t_periods();
    t_off();
    t_kick();
    t_lowv();
    t_nv();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
